// [rtl/tamap_pkg.sv]
package tamap_pkg;

  // ------------------------------------------------------------
  // Mapping modes
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    TAMAP_NULL   = 2'h0,  // Straight 48-byte slicing
    TAMAP_SINGLE = 2'h1,  // One adaptation byte, 47-byte segments
    TAMAP_DUAL   = 2'h2   // Two adaptation bytes, prefix dropped
  } tamap_mode_t;

  // ------------------------------------------------------------
  // Cell and packet geometry
  // ------------------------------------------------------------
  localparam logic [5:0] CELL_LEN   = 6'h35;  // 53 bytes per cell
  localparam logic [5:0] CELL_LAST  = 6'h34;  // Index of last cell byte
  localparam logic [5:0] HDR_LEN    = 6'h05;  // Network header bytes
  localparam logic [5:0] INFO_LEN   = 6'h30;  // 48-byte information field
  localparam logic [5:0] AAL_MAX    = 6'h04;  // Adaptation bytes allowed at most
  localparam logic [5:0] SEG_SINGLE = 6'h2F;  // 47-byte segment
  localparam logic [5:0] SEG_DUAL   = 6'h2E;  // 46-byte piece
  localparam logic [7:0] PKT_LAST   = 8'hBB;  // Index of byte 187
  localparam logic [7:0] PFX_LEN    = 8'h04;  // Packet prefix bytes
  localparam logic [7:0] PFX_FLAGS  = 8'h03;  // Prefix byte with control flags
  localparam logic [7:0] SYNC_BYTE  = 8'h47;  // Packet sync value
  localparam logic [5:0] HDR_B0     = 6'h00;  // Flow control + path high
  localparam logic [5:0] HDR_B1     = 6'h01;  // Path low + circuit high
  localparam logic [5:0] HDR_B2     = 6'h02;  // Circuit middle
  localparam logic [5:0] HDR_B3     = 6'h03;  // Circuit low + type + priority
  localparam logic [5:0] HDR_B4     = 6'h04;  // Header check byte
  localparam logic [5:0] AAL_B1     = 6'h06;  // Second adaptation byte slot

  // Adaptation byte count per mode
  function automatic logic [5:0] aal_len(input tamap_mode_t m);
    case (m)
      TAMAP_SINGLE: aal_len = 6'h01;
      TAMAP_DUAL:   aal_len = 6'h02;
      default:      aal_len = 6'h00;
    endcase
  endfunction

endpackage

// [rtl/tamap_top.sv]
`timescale 1ns/1ns
// Notes on behaviour
// - every cell is 5 header plus 48 bytes
// - header starts with 4-bit flow control
// - 8-bit path identifier follows flow control
// - 16-bit circuit identifier follows path identifier
// - header holds one cell loss priority bit
// - header ends with 8-bit check byte
// - at most four adaptation bytes per cell
// - packets are 4-byte prefix plus 184 bytes
// - null mode slices stream into 48-byte pieces
// - null mode forces no packet alignment
// - single mode uses four 47-byte segments
// - single mode adds one adaptation byte
// - adaptation byte carries segment position
// - dual mode drops prefix, four 46-byte pieces
// - dual mode adds two adaptation bytes
// - dual adaptation byte carries prefix control flags
module tamap_top (
  input  wire logic                 i_clk,
  input  wire logic                 i_rstn,
  input  wire tamap_pkg::tamap_mode_t i_mode,
  input  wire logic [3:0]           i_gfc,
  input  wire logic [7:0]           i_vpi,
  input  wire logic [15:0]          i_vci,
  input  wire logic [2:0]           i_pt,
  input  wire logic                 i_clp,
  input  wire logic [7:0]           i_hec,
  input  wire logic [5:0]           i_aal_tag,
  input  wire logic [12:0]          i_rx_pid,
  input  wire logic                 i_pkt_valid,
  input  wire logic [7:0]           i_pkt_data,
  output logic                      o_pkt_ready,
  output logic                      o_cell_valid,
  output logic [7:0]                o_cell_data,
  output logic                      o_cell_soc,
  input  wire logic                 i_cell_ready,
  input  wire logic                 i_rx_cell_valid,
  input  wire logic [7:0]           i_rx_cell_data,
  output logic                      o_rx_cell_ready,
  output logic                      o_rx_pkt_valid,
  output logic [7:0]                o_rx_pkt_data,
  output logic                      o_rx_pkt_sop,
  input  wire logic                 i_rx_pkt_ready
);

  // ------------------------------------------------------------
  // Transmit side: packets to cells
  // ------------------------------------------------------------
  tamap_pkg::tamap_mode_t tx_mode_ff;   // Mode held for current packet
  tamap_pkg::tamap_mode_t tx_mode;      // Mode in force this cycle
  logic [5:0]             tx_cb_ff;     // Byte index within cell
  logic [7:0]             tx_pp_ff;     // Byte index within packet
  logic [1:0]             tx_seg_ff;    // Segment number within packet
  logic [7:0]             tx_flags_ff;  // Captured prefix control byte
  logic                   tx_vld_ff;    // Output byte held
  logic [7:0]             tx_dat_ff;    // Output byte
  logic                   tx_soc_ff;    // Output byte opens a cell
  logic [5:0]             tx_aal_n;     // Adaptation bytes this mode
  logic                   tx_adv;       // Output stage can take a byte
  logic                   tx_hdr;       // Header region
  logic                   tx_aal;       // Adaptation region
  logic                   tx_pay;       // Payload region
  logic                   tx_drop;      // Discarding packet prefix
  logic                   tx_take;      // Input byte consumed
  logic                   tx_gen;       // Cell byte produced
  logic                   tx_pstart;    // At a packet and cell boundary
  logic [7:0]             tx_byte;      // Byte for the output stage

  // Mode may only switch where a cell and a packet both begin
  assign tx_pstart = (tx_cb_ff == 6'h00) && (tx_pp_ff == 8'h00);
  assign tx_mode   = tx_pstart ? i_mode : tx_mode_ff;
  assign tx_aal_n  = tamap_pkg::aal_len(tx_mode);
  assign tx_adv    = !tx_vld_ff || i_cell_ready;
  assign tx_hdr    = tx_cb_ff < tamap_pkg::HDR_LEN;
  assign tx_aal    = !tx_hdr && (tx_cb_ff < tamap_pkg::HDR_LEN + tx_aal_n);
  assign tx_pay    = !tx_hdr && !tx_aal;
  // Prefix bytes are swallowed before the first cell header
  assign tx_drop   = (tx_cb_ff == 6'h00) && (tx_mode == tamap_pkg::TAMAP_DUAL)
                     && (tx_pp_ff < tamap_pkg::PFX_LEN);
  assign o_pkt_ready = tx_adv && (tx_drop || tx_pay);
  assign tx_take   = o_pkt_ready && i_pkt_valid;
  assign tx_gen    = tx_adv && !tx_drop && (!tx_pay || i_pkt_valid);

  // Byte selection for header, adaptation and payload regions
  always_comb begin
    tx_byte = i_pkt_data;
    if (tx_hdr) begin
      case (tx_cb_ff)
        tamap_pkg::HDR_B0: tx_byte = {i_gfc, i_vpi[7:4]};
        tamap_pkg::HDR_B1: tx_byte = {i_vpi[3:0], i_vci[15:12]};
        tamap_pkg::HDR_B2: tx_byte = i_vci[11:4];
        tamap_pkg::HDR_B3: tx_byte = {i_vci[3:0], i_pt, i_clp};
        default:           tx_byte = i_hec;
      endcase
    end else if (tx_aal) begin
      // First adaptation byte tells the segment position
      if (tx_cb_ff == tamap_pkg::HDR_LEN) begin
        tx_byte = {i_aal_tag, tx_seg_ff};
      end else begin
        tx_byte = tx_flags_ff;
      end
    end
  end

  // Cell byte counter; wraps after 53 bytes
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tx_cb_ff <= 6'h00;
    end else if (tx_gen) begin
      tx_cb_ff <= (tx_cb_ff == tamap_pkg::CELL_LAST) ? 6'h00 : tx_cb_ff + 6'h01;
    end
  end

  // Packet byte counter; runs across cells, so null mode drifts freely
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tx_pp_ff <= 8'h00;
    end else if (tx_take) begin
      tx_pp_ff <= (tx_pp_ff == tamap_pkg::PKT_LAST) ? 8'h00 : tx_pp_ff + 8'h01;
    end
  end

  // Mode latch and segment count; 4 segments per packet wrap the 2-bit count
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tx_mode_ff <= tamap_pkg::TAMAP_NULL;
      tx_seg_ff  <= 2'h0;
    end else if (tx_pstart && (tx_gen || tx_take)) begin
      tx_mode_ff <= i_mode;
      tx_seg_ff  <= 2'h0;
    end else if (tx_gen && tx_cb_ff == tamap_pkg::CELL_LAST) begin
      tx_seg_ff  <= tx_seg_ff + 2'h1;
    end
  end

  // Keep the prefix control byte; the far end cannot rebuild it
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tx_flags_ff <= 8'h00;
    end else if (tx_take && tx_pp_ff == tamap_pkg::PFX_FLAGS) begin
      tx_flags_ff <= i_pkt_data;
    end
  end

  // Output register so cell data comes straight from flops
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tx_vld_ff <= 1'b0;
      tx_dat_ff <= 8'h00;
      tx_soc_ff <= 1'b0;
    end else if (tx_adv) begin
      tx_vld_ff <= tx_gen;
      tx_dat_ff <= tx_byte;
      tx_soc_ff <= tx_gen && (tx_cb_ff == 6'h00);
    end
  end

  assign o_cell_valid = tx_vld_ff;
  assign o_cell_data  = tx_dat_ff;
  assign o_cell_soc   = tx_soc_ff;

  // ------------------------------------------------------------
  // Receive side: cells to packets
  // ------------------------------------------------------------
  tamap_pkg::tamap_mode_t rx_mode_ff;   // Mode held for current packet
  tamap_pkg::tamap_mode_t rx_mode;      // Mode in force this cycle
  logic [5:0]             rx_cb_ff;     // Byte index within cell
  logic [7:0]             rx_pp_ff;     // Byte index within rebuilt packet
  logic [7:0]             rx_flags_ff;  // Control byte from adaptation slot
  logic                   rx_vld_ff;    // Packet byte held
  logic [7:0]             rx_dat_ff;    // Packet byte
  logic                   rx_sop_ff;    // Packet byte opens a packet
  logic [5:0]             rx_aal_n;     // Adaptation bytes this mode
  logic                   rx_adv;       // Output stage can take a byte
  logic                   rx_pay;       // Payload region
  logic                   rx_ins;       // Inserting a rebuilt prefix byte
  logic                   rx_take;      // Cell byte consumed
  logic                   rx_emit;      // Packet byte produced
  logic [7:0]             rx_byte;      // Byte for the output stage

  assign rx_mode  = (rx_cb_ff == 6'h00 && rx_pp_ff == 8'h00) ? i_mode : rx_mode_ff;
  assign rx_aal_n = tamap_pkg::aal_len(rx_mode);
  assign rx_adv   = !rx_vld_ff || i_rx_pkt_ready;
  assign rx_pay   = rx_cb_ff >= tamap_pkg::HDR_LEN + rx_aal_n;
  // Prefix is rebuilt ahead of the first payload byte in dual mode
  assign rx_ins   = rx_pay && (rx_mode == tamap_pkg::TAMAP_DUAL)
                    && (rx_pp_ff < tamap_pkg::PFX_LEN);
  assign o_rx_cell_ready = rx_adv && !rx_ins;
  assign rx_take  = o_rx_cell_ready && i_rx_cell_valid;
  assign rx_emit  = rx_adv && (rx_ins || (rx_pay && i_rx_cell_valid));

  // Rebuilt prefix: sync, identifier from call setup, carried flags
  always_comb begin
    rx_byte = i_rx_cell_data;
    if (rx_ins) begin
      case (rx_pp_ff[1:0])
        2'h0:    rx_byte = tamap_pkg::SYNC_BYTE;
        2'h1:    rx_byte = {3'h0, i_rx_pid[12:8]};
        2'h2:    rx_byte = i_rx_pid[7:0];
        default: rx_byte = rx_flags_ff;
      endcase
    end
  end

  // Cell byte counter; header and adaptation bytes are skipped
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rx_cb_ff <= 6'h00;
    end else if (rx_take) begin
      rx_cb_ff <= (rx_cb_ff == tamap_pkg::CELL_LAST) ? 6'h00 : rx_cb_ff + 6'h01;
    end
  end

  // Packet byte counter in arrival order
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rx_pp_ff <= 8'h00;
    end else if (rx_emit) begin
      rx_pp_ff <= (rx_pp_ff == tamap_pkg::PKT_LAST) ? 8'h00 : rx_pp_ff + 8'h01;
    end
  end

  // Mode latch at a cell start that is also a packet start
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rx_mode_ff <= tamap_pkg::TAMAP_NULL;
    end else if (rx_take && rx_cb_ff == 6'h00 && rx_pp_ff == 8'h00) begin
      rx_mode_ff <= i_mode;
    end
  end

  // Second adaptation byte carries the prefix control flags
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rx_flags_ff <= 8'h00;
    end else if (rx_take && rx_mode == tamap_pkg::TAMAP_DUAL && rx_cb_ff == tamap_pkg::AAL_B1) begin
      rx_flags_ff <= i_rx_cell_data;
    end
  end

  // Output register toward the packet sink
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rx_vld_ff <= 1'b0;
      rx_dat_ff <= 8'h00;
      rx_sop_ff <= 1'b0;
    end else if (rx_adv) begin
      rx_vld_ff <= rx_emit;
      rx_dat_ff <= rx_byte;
      rx_sop_ff <= rx_emit && (rx_pp_ff == 8'h00);
    end
  end

  assign o_rx_pkt_valid = rx_vld_ff;
  assign o_rx_pkt_data  = rx_dat_ff;
  assign o_rx_pkt_sop   = rx_sop_ff;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  logic [5:0] chk_cnt_ff;  // Accepted output cell bytes, modulo 53

  // Helper count; a short or long cell shows as a misplaced start flag
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      chk_cnt_ff <= 6'h00;
    end else if (o_cell_valid && i_cell_ready) begin
      chk_cnt_ff <= (chk_cnt_ff == tamap_pkg::CELL_LAST) ? 6'h00 : chk_cnt_ff + 6'h01;
    end
  end

  a_cell_length: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_cell_valid |-> (o_cell_soc == (chk_cnt_ff == 6'h00)))
    else $error("cell start flag not every 53 bytes");

  a_hdr_flow: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (tx_gen && tx_adv && tx_cb_ff == tamap_pkg::HDR_B0) |=> o_cell_data[7:4] == $past(i_gfc))
    else $error("flow control nibble wrong");

  a_hdr_path: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (tx_gen && tx_cb_ff == tamap_pkg::HDR_B1) |=> o_cell_data[7:4] == $past(i_vpi[3:0]))
    else $error("path identifier low nibble wrong");

  a_hdr_circuit: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (tx_gen && tx_cb_ff == tamap_pkg::HDR_B2) |=> o_cell_data == $past(i_vci[11:4]))
    else $error("circuit identifier byte wrong");

  a_hdr_priority: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (tx_gen && tx_cb_ff == tamap_pkg::HDR_B3) |=> o_cell_data[0] == $past(i_clp))
    else $error("cell loss priority bit wrong");

  a_hdr_check: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (tx_gen && tx_cb_ff == tamap_pkg::HDR_B4) |=> o_cell_data == $past(i_hec))
    else $error("header check byte wrong");

  a_aal_bound: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (tx_gen && tx_pay) |-> tx_cb_ff >= tamap_pkg::CELL_LEN - tamap_pkg::INFO_LEN + tx_aal_n
      && tx_aal_n <= tamap_pkg::AAL_MAX)
    else $error("payload started too early");

  a_single_align: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (tx_gen && tx_cb_ff == 6'h00 && tx_mode_ff == tamap_pkg::TAMAP_SINGLE && !tx_pstart)
      |-> tx_pp_ff == 8'(tx_seg_ff) * 8'(tamap_pkg::SEG_SINGLE))
    else $error("single mode segment misaligned");

  a_dual_drop: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (tx_take && tx_mode == tamap_pkg::TAMAP_DUAL && tx_pp_ff < tamap_pkg::PFX_LEN) |=> !o_cell_valid)
    else $error("prefix byte leaked into a cell");

  a_dual_piece: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (tx_gen && tx_cb_ff == 6'h00 && tx_mode_ff == tamap_pkg::TAMAP_DUAL && !tx_pstart)
      |-> tx_pp_ff == 8'(tx_seg_ff) * 8'(tamap_pkg::SEG_DUAL) + tamap_pkg::PFX_LEN)
    else $error("dual mode piece misaligned");

  a_rx_sop: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (rx_emit && rx_adv && rx_pp_ff == 8'h00 && rx_mode == tamap_pkg::TAMAP_DUAL)
      |=> o_rx_pkt_sop && o_rx_pkt_data == tamap_pkg::SYNC_BYTE)
    else $error("rebuilt packet does not open with sync");

  a_rx_pid: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (rx_emit && rx_ins && rx_pp_ff == 8'h02) |=> o_rx_pkt_data == $past(i_rx_pid[7:0]))
    else $error("rebuilt identifier low byte wrong");

  logic [5:0] chk_pay_ff;  // Payload bytes produced so far in this cell

  // Payload share of a cell; a region boundary off by one shows up here
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      chk_pay_ff <= 6'h00;
    end else if (tx_gen && tx_cb_ff == tamap_pkg::CELL_LAST) begin
      chk_pay_ff <= 6'h00;
    end else if (tx_gen && tx_pay) begin
      chk_pay_ff <= chk_pay_ff + 6'h01;
    end
  end

  a_pay_count: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (tx_gen && tx_cb_ff == tamap_pkg::CELL_LAST) |-> chk_pay_ff + 6'h01 == tamap_pkg::INFO_LEN - tx_aal_n)
    else $error("payload byte count per cell wrong");

  c_single_cell: cover property (@(posedge i_clk) disable iff (!i_rstn)
    tx_gen && tx_mode_ff == tamap_pkg::TAMAP_SINGLE && tx_cb_ff == tamap_pkg::CELL_LAST);
  c_dual_cell: cover property (@(posedge i_clk) disable iff (!i_rstn)
    tx_gen && tx_mode_ff == tamap_pkg::TAMAP_DUAL && tx_cb_ff == tamap_pkg::CELL_LAST);
  c_null_realign: cover property (@(posedge i_clk) disable iff (!i_rstn)
    tx_gen && tx_pstart && tx_mode_ff == tamap_pkg::TAMAP_NULL);
  c_rx_packet: cover property (@(posedge i_clk) disable iff (!i_rstn)
    rx_emit && rx_pp_ff == tamap_pkg::PKT_LAST);

endmodule

// [verif/tamap_link_model.sv]
`timescale 1ns/1ns
// ------------------------------------------------------------
// Link layer partner: takes cells, replays them on receive side
// ------------------------------------------------------------
module tamap_link_model (
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_cell_valid,
  input  wire logic [7:0] i_cell_data,
  output logic            o_cell_ready,
  output logic            o_rx_cell_valid,
  output logic [7:0]      o_rx_cell_data,
  input  wire logic       i_rx_cell_ready,
  input  wire logic       i_hold
);
  logic [7:0] q[$];     // Cell bytes waiting to be sent back
  logic       tx_take;  // Transfer seen on transmit side
  logic       rx_take;  // Transfer seen on receive side
  logic [7:0] tx_byte;  // Byte taken from the mapper

  initial begin
    o_cell_ready    = 1'b0;
    o_rx_cell_valid = 1'b0;
    o_rx_cell_data  = 8'h00;
    tx_take         = 1'b0;
    rx_take         = 1'b0;
  end

  // Handshakes sampled mid-cycle, where every line has settled
  always @(negedge i_clk) begin
    tx_take = i_cell_valid && o_cell_ready;
    tx_byte = i_cell_data;
    rx_take = o_rx_cell_valid && i_rx_cell_ready;
  end

  // Random stalls on both sides; an idle data line keeps toggling so stale bytes never match
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      q.delete();
      o_cell_ready    <= 1'b0;
      o_rx_cell_valid <= 1'b0;
    end else begin
      if (tx_take) begin
        q.push_back(tx_byte);
      end
      o_cell_ready <= ($urandom % 4) != 0;
      if (!o_rx_cell_valid || rx_take) begin
        // Hold keeps new bytes back, so no receive packet start meets a mode flip
        if (q.size() != 0 && !i_hold && ($urandom % 4) != 0) begin
          o_rx_cell_valid <= 1'b1;
          o_rx_cell_data  <= q.pop_front();
        end else begin
          o_rx_cell_valid <= 1'b0;
          o_rx_cell_data  <= ~o_rx_cell_data;
        end
      end
    end
  end
endmodule

// [verif/transport_to_atm_cell_mapper_tb.sv]
`timescale 1ns/1ns
module transport_to_atm_cell_mapper_tb;
  logic                  i_clk, i_rstn, pkt_valid, rx_pkt_ready, clp, hold;
  tamap_pkg::tamap_mode_t mode;
  logic [3:0]            gfc;
  logic [7:0]            vpi, hec, pkt_data;
  logic [15:0]           vci;
  logic [2:0]            pt;
  logic [5:0]            tag;
  logic [12:0]           pid;
  wire logic             pkt_ready, cell_valid, cell_soc, cell_ready, rx_cell_valid, rx_cell_ready;
  wire logic             rx_pkt_valid, rx_pkt_sop;
  wire logic [7:0]       cell_data, rx_cell_data, rx_pkt_data;
  int                    err_count, check_count, cell_n, pkt_n;
  logic [7:0]            pkt[$], exp_cell[$], exp_pkt[$];  // Sent stream and expectations

  tamap_top dut_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_mode(mode), .i_gfc(gfc), .i_vpi(vpi), .i_vci(vci),
    .i_pt(pt), .i_clp(clp), .i_hec(hec), .i_aal_tag(tag), .i_rx_pid(pid), .i_pkt_valid(pkt_valid),
    .i_pkt_data(pkt_data), .o_pkt_ready(pkt_ready), .o_cell_valid(cell_valid), .o_cell_data(cell_data),
    .o_cell_soc(cell_soc), .i_cell_ready(cell_ready), .i_rx_cell_valid(rx_cell_valid),
    .i_rx_cell_data(rx_cell_data), .o_rx_cell_ready(rx_cell_ready), .o_rx_pkt_valid(rx_pkt_valid),
    .o_rx_pkt_data(rx_pkt_data), .o_rx_pkt_sop(rx_pkt_sop), .i_rx_pkt_ready(rx_pkt_ready));

  tamap_link_model link_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_cell_valid(cell_valid), .i_cell_data(cell_data),
    .o_cell_ready(cell_ready), .o_rx_cell_valid(rx_cell_valid), .o_rx_cell_data(rx_cell_data),
    .i_rx_cell_ready(rx_cell_ready), .i_hold(hold));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // ------------------------------------------------------------
  // Compare and closing tasks
  // ------------------------------------------------------------
  task automatic chk_cell(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t cell byte got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_pkt(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t packet byte got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_mark(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t start marker got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    if (err_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Reference model: cell stream expected from the packet stream
  // ------------------------------------------------------------
  task automatic build(input tamap_pkg::tamap_mode_t m);
    int p, c, n;
    p = 0;
    c = 0;
    n = (m == tamap_pkg::TAMAP_SINGLE) ? 47 : (m == tamap_pkg::TAMAP_DUAL) ? 46 : 48;
    // Outside dual mode the next cell's header leaves before any payload, so it closes the stream
    while (p <= pkt.size()) begin
      if (m == tamap_pkg::TAMAP_DUAL && p % 188 == 0) begin
        if (p == pkt.size()) begin
          break;  // Dual mode waits for prefix bytes first
        end
        p += 4;  // Prefix never travels in dual mode
      end
      exp_cell.push_back({gfc, vpi[7:4]});
      exp_cell.push_back({vpi[3:0], vci[15:12]});
      exp_cell.push_back(vci[11:4]);
      exp_cell.push_back({vci[3:0], pt, clp});
      exp_cell.push_back(hec);
      if (m == tamap_pkg::TAMAP_SINGLE || m == tamap_pkg::TAMAP_DUAL) begin
        exp_cell.push_back({tag, 2'(c % 4)});
      end
      if (p == pkt.size()) begin
        break;
      end
      if (m == tamap_pkg::TAMAP_DUAL) begin
        exp_cell.push_back(pkt[(p / 188) * 188 + 3]);
      end
      for (int k = 0; k < n; k++) begin
        exp_cell.push_back(pkt[p]);
        p++;
      end
      c++;
    end
  endtask

  // Monitors sample mid-cycle, where handshakes are settled
  always @(negedge i_clk) begin
    if (i_rstn && cell_valid && cell_ready) begin
      chk_mark(cell_soc, (cell_n % 53) == 0);
      chk_cell(cell_data, (exp_cell.size() != 0) ? exp_cell.pop_front() : 8'hXX);
      cell_n++;
    end
    if (i_rstn && rx_pkt_valid && rx_pkt_ready) begin
      chk_mark(rx_pkt_sop, (pkt_n % 188) == 0);
      chk_pkt(rx_pkt_data, (exp_pkt.size() != 0) ? exp_pkt.pop_front() : 8'hXX);
      pkt_n++;
    end
  end

  // Packet sink stalls at random
  always @(posedge i_clk) begin
    rx_pkt_ready <= ($urandom % 4) != 0;
  end

  // ------------------------------------------------------------
  // One run per mode code: 12 packets, so null mode ends on a cell edge
  // ------------------------------------------------------------
  task automatic run(input int mi);
    int w;
    logic ok;
    @(posedge i_clk);
    i_rstn <= 1'b0;
    mode   <= tamap_pkg::tamap_mode_t'(mi[1:0]);
    hold   <= 1'b1;
    {gfc, vpi, vci, pt, clp, hec} <= 40'({$urandom, $urandom});
    tag    <= 6'($urandom);
    pid    <= 13'($urandom);
    repeat (2) @(posedge i_clk);
    i_rstn <= 1'b1;
    pkt.delete();
    for (int i = 0; i < 12 * 188; i++) begin
      pkt.push_back((i % 188 == 0) ? 8'h47 : (i % 188 == 1) ? {3'h0, pid[12:8]} :
                    (i % 188 == 2) ? pid[7:0] : 8'($urandom));
    end
    exp_pkt = pkt;
    cell_n  = 0;
    pkt_n   = 0;
    build(mode);
    foreach (pkt[i]) begin
      if ($urandom % 8 == 0) begin
        pkt_valid <= 1'b0;
        @(posedge i_clk);
      end
      pkt_valid <= 1'b1;
      pkt_data  <= pkt[i];
      // A mode flip inside a packet must not reach the cells
      if (i % 188 == 60) begin
        mode <= tamap_pkg::tamap_mode_t'(2'(mi + 1));
      end
      if (i % 188 == 120) begin
        mode <= tamap_pkg::tamap_mode_t'(mi[1:0]);
      end
      w = 0;
      do begin
        @(negedge i_clk);
        ok = pkt_ready;
        @(posedge i_clk);
        w++;
      end while (ok !== 1'b1 && w < 500);
      if (ok !== 1'b1) begin
        err_count++;
        close_out();
      end
    end
    pkt_valid <= 1'b0;
    hold      <= 1'b0;  // Receive side replays once the mode is steady again
    w = 0;
    while ((exp_cell.size() != 0 || exp_pkt.size() != 0) && w < 20000) begin
      @(posedge i_clk);
      w++;
    end
    if (w >= 20000) begin
      err_count++;
      close_out();
    end
  endtask

  initial begin
    err_count    = 0;
    check_count  = 0;
    i_rstn       = 1'b0;
    mode         = tamap_pkg::TAMAP_NULL;
    {gfc, vpi, vci, pt, clp, hec, tag, pid} = '0;
    pkt_valid    = 1'b0;
    hold         = 1'b1;
    pkt_data     = 8'h00;
    rx_pkt_ready = 1'b0;
    void'($urandom(72895));
    for (int mi = 0; mi < 4; mi++) begin
      run(mi);
    end
    close_out();
  end
endmodule
